/* rtl/keylock_pkg.sv */
// shared constants, types and helpers of the keypad interlock front end
package keylock_pkg;

  // clock rate and documented time figures
  localparam int CLK_MHZ = 100;
  localparam int FILT_US = 2000;
  localparam int FILT_CYC = FILT_US * CLK_MHZ;
  localparam int HOLD_MS = 2000;
  localparam int HOLD_CYC = HOLD_MS * 1000 * CLK_MHZ;
  localparam int IDLE_MS = 10000;
  localparam int IDLE_CYC = IDLE_MS * 1000 * CLK_MHZ;

  // register byte offsets
  localparam logic [7:0] ADDR_LOCK = 8'h00;
  localparam logic [7:0] ADDR_INCFG = 8'h04;
  localparam logic [7:0] ADDR_KEYCMD = 8'h08;
  localparam logic [7:0] ADDR_PROT = 8'h0C;
  localparam logic [7:0] ADDR_PWD = 8'h10;
  localparam logic [7:0] ADDR_STAT = 8'h14;
  localparam logic [7:0] ADDR_MEAS = 8'h18;

  // field positions
  localparam int LOCK1_BIT = 0;
  localparam int LOCK2_BIT = 1;
  localparam int DEFAULT_BIT = 2;
  localparam int FUNC_LSB = 4;
  localparam int FUNC_W = 3;
  localparam int PWD_GRP_LSB = 16;

  // key line indices
  localparam int KEY_MENU = 0;
  localparam int KEY_UP = 1;
  localparam int KEY_DOWN = 2;
  localparam int KEY_ENTER = 3;

  localparam int NUM_IN = 4;
  localparam int NUM_GROUPS = 7;
  localparam int GRP_W = 3;
  localparam int PWD_W = 16;

  // values after reset and after a factory default
  localparam logic [15:0] RST_INCFG = 16'h0000;
  localparam logic [5:0] RST_KEYCMD = 6'h00;
  localparam logic [6:0] RST_PROT = 7'h00;

  typedef enum logic [2:0] {FN_NONE, FN_LOCK1, FN_LOCK2, FN_SWAP, FN_FREEZE} in_func_e;
  typedef enum logic [1:0] {KC_NONE, KC_SWAP, KC_FREEZE, KC_PULSE} key_cmd_e;
  typedef enum logic [2:0] {
    ST_BOOT, ST_NORMAL, ST_HOLD, ST_MENU, ST_PARAM, ST_SETTING, ST_ASK_PWD
  } ui_state_e;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_s;

  typedef struct packed {
    logic dir_swap;
    logic freeze;
    logic lock1;
    logic lock2;
    logic setup_active;
    logic cmd_pulse;
    logic [GRP_W-1:0] group;
  } ui_out_s;

  // control input asserted for its polarity (pol 1 = active low)
  function automatic logic in_active(input logic lvl, input logic pol);
    return lvl ^ pol;
  endfunction

endpackage

/* rtl/level_filter.sv */
// two-flop synchroniser and stability filter for slow external lines
`timescale 1ns/1ps
module level_filter #(
  parameter int W = 8,
  parameter int CYC = 200000
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] raw,
  output logic [W-1:0] filt
);
  import keylock_pkg::*;

  localparam int CW = $clog2(CYC + 1);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] out;
    logic [W-1:0][CW-1:0] cnt;
  } flt_s;

  flt_s st_ff;
  flt_s nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.s1 = raw;
    nxt_st.s2 = st_ff.s1;
    for (int i = 0; i < W; i++) begin
      if (st_ff.s2[i] == st_ff.out[i]) begin
        nxt_st.cnt[i] = '0;
      end else if (st_ff.cnt[i] == CW'(CYC - 1)) begin
        nxt_st.out[i] = st_ff.s2[i];
        nxt_st.cnt[i] = '0;
      end else begin
        nxt_st.cnt[i] = st_ff.cnt[i] + 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign filt = st_ff.out;
endmodule

/* rtl/pwd_mem.sv */
// per-group password store with registered read data
`timescale 1ns/1ps
module pwd_mem #(
  parameter int DEPTH = 8,
  parameter int W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic we,
  input wire logic [$clog2(DEPTH)-1:0] waddr,
  input wire logic [W-1:0] wdata,
  input wire logic [$clog2(DEPTH)-1:0] raddr,
  output logic [W-1:0] rdata
);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [W-1:0] rd;
  } mem_s;

  mem_s st_ff;
  mem_s nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (we) begin
      nxt_st.mem[waddr] = wdata;
    end
    nxt_st.rd = st_ff.mem[raddr];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rdata = st_ff.rd;
endmodule

/* rtl/keylock_ctrl.sv */
// keypad, control input and key interlock front end with apb registers
//
// Behaviour
// - Each control input has a polarity bit choosing active low or active high.
// - Each control input takes a function: lock, direction swap or output freeze.
// - In normal operation an up, down or enter key press runs the command set for that key.
// - Four keys (menu select, up, down, enter) are decoded per operating state.
// - Protection has open, per-group password, latch one and latch two stages.
// - Each group has its own password, checked before a protected group opens.
// - A password not given in time denies access and returns to normal operation.
// - A control input with a latch function sets and clears that latch by level.
// - The latches can also be set and cleared by a host through a lock register.
// - Lockout ends by inactive inputs, factory defaults or a host rewrite.
// - A host may change settings and read states and measured values while running.
// - The second host link gives the same access as the first one.
// - Setup opens only after the menu select key is held 2 s in normal operation.
// - Ten seconds with no key moves the menu back one level.
`timescale 1ns/1ps
module keylock_ctrl #(
  parameter int FILT_CYCLES = keylock_pkg::FILT_CYC,
  parameter int HOLD_CYCLES = keylock_pkg::HOLD_CYC,
  parameter int IDLE_CYCLES = keylock_pkg::IDLE_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire keylock_pkg::apb_req_s apb_i,
  output keylock_pkg::apb_rsp_s apb_o,
  input wire logic [3:0] key_raw,
  input wire logic [keylock_pkg::NUM_IN-1:0] ctrl_raw,
  input wire logic [31:0] meas_value,
  output keylock_pkg::ui_out_s ui_o
);
  import keylock_pkg::*;

  typedef struct packed {
    apb_rsp_s rsp;
    logic lock1_reg;
    logic lock2_reg;
    logic [15:0] incfg;
    logic [5:0] keycmd;
    logic [6:0] prot;
    ui_state_e state;
    logic [31:0] tmr;
    logic [3:0] param;
    logic [PWD_W-1:0] entry;
    logic [3:0] keys_q;
    logic swap_tgl;
    logic frz_tgl;
    ui_out_s ui;
  } st_s;

  st_s st_ff;
  st_s nxt_st;

  logic [7:0] filt;
  logic [3:0] keys;
  logic [NUM_IN-1:0] ins;
  logic [3:0] hit;
  logic req1;
  logic req2;
  logic swap_lvl;
  logic frz_lvl;
  logic setup_cyc;
  logic wr_acc;
  logic pwd_we;
  logic [PWD_W-1:0] pwd_rd;
  logic idle_out;

  function automatic logic reg_hit(input logic [7:0] a);
    return a == ADDR_LOCK || a == ADDR_INCFG || a == ADDR_KEYCMD || a == ADDR_PROT ||
           a == ADDR_PWD || a == ADDR_STAT || a == ADDR_MEAS;
  endfunction

  function automatic logic [2:0] in_func(input logic [15:0] cfg, input int i);
    return cfg[FUNC_LSB + FUNC_W * i +: FUNC_W];
  endfunction

  level_filter #(.W(8), .CYC(FILT_CYCLES)) level_filter_i (
    .pclk(pclk),
    .presetn(presetn),
    .raw({ctrl_raw, key_raw}),
    .filt(filt)
  );

  assign keys = filt[3:0];
  assign ins = filt[7:4];
  assign setup_cyc = apb_i.psel && !apb_i.penable;
  // one register port serves both host links
  assign wr_acc = apb_i.psel && apb_i.penable && st_ff.rsp.pready && apb_i.pwrite;
  assign pwd_we = wr_acc && apb_i.paddr == ADDR_PWD;

  pwd_mem #(.DEPTH(8), .W(PWD_W)) pwd_mem_i (
    .pclk(pclk),
    .presetn(presetn),
    .we(pwd_we),
    .waddr(apb_i.pwdata[PWD_GRP_LSB +: GRP_W]),
    .wdata(apb_i.pwdata[PWD_W-1:0]),
    .raddr(st_ff.ui.group),
    .rdata(pwd_rd)
  );

  always_comb begin
    req1 = 1'b0;
    req2 = 1'b0;
    swap_lvl = 1'b0;
    frz_lvl = 1'b0;
    for (int i = 0; i < NUM_IN; i++) begin
      if (in_active(ins[i], st_ff.incfg[i])) begin
        req1 = req1 | (in_func(st_ff.incfg, i) == FN_LOCK1);
        req2 = req2 | (in_func(st_ff.incfg, i) == FN_LOCK2);
        swap_lvl = swap_lvl | (in_func(st_ff.incfg, i) == FN_SWAP);
        frz_lvl = frz_lvl | (in_func(st_ff.incfg, i) == FN_FREEZE);
      end
    end
  end

  assign hit = st_ff.ui.lock2 ? 4'h0 : (keys & ~st_ff.keys_q);
  assign idle_out = st_ff.tmr == 32'(IDLE_CYCLES - 1) && hit == 4'h0;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.rsp.pready = 1'b0;
    nxt_st.ui.cmd_pulse = 1'b0;
    nxt_st.keys_q = keys;
    nxt_st.tmr = st_ff.tmr + 32'h1;
    if (setup_cyc) begin
      nxt_st.rsp.pready = 1'b1;
      nxt_st.rsp.pslverr = !reg_hit(apb_i.paddr);
      case (apb_i.paddr)
        ADDR_LOCK: nxt_st.rsp.prdata = {30'h0, st_ff.lock2_reg, st_ff.lock1_reg};
        ADDR_INCFG: nxt_st.rsp.prdata = {16'h0, st_ff.incfg};
        ADDR_KEYCMD: nxt_st.rsp.prdata = {26'h0, st_ff.keycmd};
        ADDR_PROT: nxt_st.rsp.prdata = {25'h0, st_ff.prot};
        ADDR_STAT: nxt_st.rsp.prdata = {11'h0, filt, 1'b0, st_ff.state, st_ff.ui};
        ADDR_MEAS: nxt_st.rsp.prdata = meas_value;
        default: nxt_st.rsp.prdata = 32'h0;
      endcase
    end
    if (wr_acc) begin
      case (apb_i.paddr)
        ADDR_LOCK: begin
          nxt_st.lock1_reg = apb_i.pwdata[LOCK1_BIT];
          nxt_st.lock2_reg = apb_i.pwdata[LOCK2_BIT];
          if (apb_i.pwdata[DEFAULT_BIT]) begin
            nxt_st.incfg = RST_INCFG;
            nxt_st.keycmd = RST_KEYCMD;
            nxt_st.prot = RST_PROT;
            nxt_st.lock1_reg = 1'b0;
            nxt_st.lock2_reg = 1'b0;
          end
        end
        ADDR_INCFG: nxt_st.incfg = apb_i.pwdata[15:0];
        ADDR_KEYCMD: nxt_st.keycmd = apb_i.pwdata[5:0];
        ADDR_PROT: nxt_st.prot = apb_i.pwdata[6:0];
        default: nxt_st.incfg = nxt_st.incfg;
      endcase
    end
    // restart idle count after every timeout step so each level times out again
    if (hit != 4'h0 || (idle_out && st_ff.ui.setup_active)) begin
      nxt_st.tmr = 32'h0;
    end
    case (st_ff.state)
      ST_BOOT: begin
        if (st_ff.tmr == 32'(2 * FILT_CYCLES)) begin
          if (keys[KEY_UP] && keys[KEY_DOWN]) begin
            nxt_st.incfg = RST_INCFG;
            nxt_st.keycmd = RST_KEYCMD;
            nxt_st.prot = RST_PROT;
          end
          nxt_st.state = ST_NORMAL;
        end
      end
      ST_NORMAL: begin
        for (int k = KEY_UP; k <= KEY_ENTER; k++) begin
          if (hit[k]) begin
            case (key_cmd_e'(st_ff.keycmd[2 * (k - 1) +: 2]))
              KC_SWAP: nxt_st.swap_tgl = !nxt_st.swap_tgl;
              KC_FREEZE: nxt_st.frz_tgl = !nxt_st.frz_tgl;
              KC_PULSE: nxt_st.ui.cmd_pulse = 1'b1;
              default: nxt_st.ui.cmd_pulse = nxt_st.ui.cmd_pulse;
            endcase
          end
        end
        if (hit[KEY_MENU] && !st_ff.ui.lock1) begin
          nxt_st.state = ST_HOLD;
          nxt_st.tmr = 32'h0;
        end
      end
      ST_HOLD: begin
        if (!keys[KEY_MENU] || st_ff.ui.lock1 || st_ff.ui.lock2) begin
          nxt_st.state = ST_NORMAL;
        end else if (st_ff.tmr == 32'(HOLD_CYCLES - 1)) begin
          nxt_st.state = ST_MENU;
          nxt_st.tmr = 32'h0;
        end
      end
      ST_MENU: begin
        if (hit[KEY_MENU] || idle_out) begin
          nxt_st.state = ST_NORMAL;
        end else if (hit[KEY_UP]) begin
          nxt_st.ui.group = st_ff.ui.group == GRP_W'(NUM_GROUPS - 1) ? '0
                          : st_ff.ui.group + 1'b1;
        end else if (hit[KEY_DOWN]) begin
          nxt_st.ui.group = st_ff.ui.group == '0 ? GRP_W'(NUM_GROUPS - 1)
                          : st_ff.ui.group - 1'b1;
        end else if (hit[KEY_ENTER]) begin
          nxt_st.param = 4'h0;
          nxt_st.entry = '0;
          // protected group asks for its password
          nxt_st.state = st_ff.prot[st_ff.ui.group] ? ST_ASK_PWD : ST_PARAM;
        end
      end
      ST_PARAM: begin
        if (hit[KEY_MENU] || idle_out) begin
          nxt_st.state = ST_MENU;
        end else if (hit[KEY_UP]) begin
          nxt_st.param = st_ff.param + 1'b1;
        end else if (hit[KEY_DOWN]) begin
          nxt_st.param = st_ff.param - 1'b1;
        end else if (hit[KEY_ENTER]) begin
          nxt_st.state = ST_SETTING;
        end
      end
      ST_SETTING: begin
        // idle timeout steps one level back
        if (hit[KEY_MENU] || idle_out) begin
          nxt_st.state = ST_PARAM;
        end
      end
      ST_ASK_PWD: begin
        // no password in time means denial
        if (idle_out) begin
          nxt_st.state = ST_NORMAL;
        end else if (hit[KEY_UP]) begin
          nxt_st.entry = st_ff.entry + 1'b1;
        end else if (hit[KEY_DOWN]) begin
          nxt_st.entry = st_ff.entry - 1'b1;
        end else if (hit[KEY_ENTER] || hit[KEY_MENU]) begin
          nxt_st.state = (hit[KEY_ENTER] && st_ff.entry == pwd_rd) ? ST_PARAM : ST_NORMAL;
        end
      end
      default: nxt_st.state = ST_NORMAL;
    endcase
    // latch one ends any setup session
    if (st_ff.ui.lock1 && st_ff.state inside {ST_MENU, ST_PARAM, ST_SETTING, ST_ASK_PWD}) begin
      nxt_st.state = ST_NORMAL;
    end
    nxt_st.ui.lock1 = req1 | st_ff.lock1_reg;
    nxt_st.ui.lock2 = req2 | st_ff.lock2_reg;
    nxt_st.ui.dir_swap = st_ff.swap_tgl ^ swap_lvl;
    nxt_st.ui.freeze = st_ff.frz_tgl | frz_lvl;
    nxt_st.ui.setup_active = nxt_st.state inside {ST_MENU, ST_PARAM, ST_SETTING, ST_ASK_PWD};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign apb_o = st_ff.rsp;
  assign ui_o = st_ff.ui;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_hold_to_menu;
    st_ff.state == ST_HOLD ##1 st_ff.state == ST_MENU;
  endsequence

  sequence s_ask_to_param;
    st_ff.state == ST_ASK_PWD ##1 st_ff.state == ST_PARAM;
  endsequence

  AST_APB_READY: assert property (setup_cyc |=> apb_o.pready)
    else $error("apb setup not answered in next cycle");
  AST_LOCK_OR: assert property (1'b1 |=> ui_o.lock2 == ($past(req2) | $past(st_ff.lock2_reg)))
    else $error("lock2 is not the or of its sources");
  AST_POLARITY: assert property ((in_func(st_ff.incfg, 0) == FN_LOCK1 &&
      ins[0] != st_ff.incfg[0]) |=> ui_o.lock1)
    else $error("active input did not set latch one");
  AST_LOCK2_BLOCK: assert property ((ui_o.lock2 && st_ff.state == ST_NORMAL) |=>
      (st_ff.state == ST_NORMAL && !ui_o.cmd_pulse))
    else $error("key acted under latch two");
  AST_HOLD: assert property (s_hold_to_menu |-> $past(st_ff.tmr) == 32'(HOLD_CYCLES - 1))
    else $error("setup opened before hold time");
  AST_IDLE: assert property ((st_ff.state == ST_SETTING && idle_out && !ui_o.lock1) |=>
      st_ff.state == ST_PARAM)
    else $error("idle timeout did not step back");
  AST_PWD_TIMEOUT: assert property ((st_ff.state == ST_ASK_PWD && idle_out) |=>
      st_ff.state == ST_NORMAL)
    else $error("password timeout did not deny access");
  AST_PWD_OK: assert property (s_ask_to_param |-> $past(st_ff.entry) == $past(pwd_rd))
    else $error("protected group opened without matching password");
  AST_DEFAULT: assert property ((wr_acc && apb_i.paddr == ADDR_LOCK &&
      apb_i.pwdata[DEFAULT_BIT]) |=> (st_ff.incfg == RST_INCFG && !st_ff.lock2_reg))
    else $error("factory default did not clear locking setup");
  AST_CMD: assert property ((st_ff.state == ST_NORMAL && hit[KEY_UP] &&
      st_ff.keycmd[1:0] == KC_SWAP) |=> st_ff.swap_tgl != $past(st_ff.swap_tgl))
    else $error("up key swap command not executed");
endmodule

/* test/operator_panel.sv */
// model of the operator keys and switched control lines
`timescale 1ns/1ps
module operator_panel #(
  parameter int MIN_HOLD = 7
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic rude,
  input wire logic [3:0] key_req,
  input wire logic [3:0] ctrl_req,
  output logic [3:0] key_raw,
  output logic [3:0] ctrl_raw
);
  int age;
  // levels held minimum time
  // rude lets a bounce scenario break the hold on purpose
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_raw <= 4'h0;
      ctrl_raw <= 4'h0;
      age <= 0;
    end else if ((rude || age >= MIN_HOLD) && {key_req, ctrl_req} != {key_raw, ctrl_raw}) begin
      key_raw <= key_req;
      ctrl_raw <= ctrl_req;
      age <= 0;
    end else if (age < MIN_HOLD) begin
      age <= age + 1;
    end
  end
endmodule

/* test/keylock_ctrl_test.sv */
// self-checking bench of the keypad interlock front end
`timescale 1ns/1ps
module keylock_ctrl_test;
  import keylock_pkg::*;
  localparam int FC = 4;
  localparam int SET = FC + 8;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  apb_req_s req = '0;
  apb_rsp_s rsp;
  ui_out_s ui;
  logic [3:0] key_req = 4'h0;
  logic [3:0] ctrl_req = 4'h0;
  logic [3:0] key_raw;
  logic [3:0] ctrl_raw;
  logic rude = 1'b0;
  logic [31:0] meas = 32'hA5C3_0F17;
  logic [31:0] rd;
  logic err;
  logic [31:0] cfg;
  logic [3:0] pm;
  int miscompares = 0;
  int compares = 0;
  int pulses = 0;
  int lock_hits = 0;
  int n;

  always #5 pclk = ~pclk;

  keylock_ctrl #(.FILT_CYCLES(FC), .HOLD_CYCLES(20), .IDLE_CYCLES(50)) keylock_ctrl_i (
    .pclk(pclk), .presetn(presetn), .apb_i(req), .apb_o(rsp),
    .key_raw(key_raw), .ctrl_raw(ctrl_raw), .meas_value(meas), .ui_o(ui));

  operator_panel #(.MIN_HOLD(FC + 3)) operator_panel_i (
    .pclk(pclk), .presetn(presetn), .rude(rude), .key_req(key_req),
    .ctrl_req(ctrl_req), .key_raw(key_raw), .ctrl_raw(ctrl_raw));

  always @(posedge pclk) begin
    if (ui.cmd_pulse === 1'b1) pulses++;
    if (ui.lock1 === 1'b1) lock_hits++;
  end

  task automatic finish_test();
    if (miscompares == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tick(input int c);
    repeat (c) @(posedge pclk);
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= wr;
    req.paddr <= a;
    req.pwdata <= d;
    @(posedge pclk);
    req.penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (rsp.pready !== 1'b1 && k < 20);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    if (rsp.pready !== 1'b1) begin
      miscompares++;
      finish_test();
    end
  endtask

  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(name, rd, exp);
  endtask

  task automatic state_is(input logic [2:0] s);
    apb(1'b0, ADDR_STAT, 32'h0);
    check("state", {29'h0, rd[11:9]}, {29'h0, s});
  endtask

  task automatic press(input int k, input int len);
    @(posedge pclk);
    key_req[k] <= 1'b1;
    tick(len);
    key_req[k] <= 1'b0;
    tick(SET);
  endtask

  task automatic wait_setup(input logic v);
    int k;
    for (k = 0; k < 120 && ui.setup_active !== v; k++) @(posedge pclk);
    check("setup_active", {31'h0, ui.setup_active}, {31'h0, v});
    if (k == 120) finish_test();
  endtask

  function automatic logic ui_bit(input int f);
    case (f)
      1: return ui.lock1;
      2: return ui.lock2;
      3: return ui.dir_swap;
      default: return ui.freeze;
    endcase
  endfunction

  initial begin
    tick(10);
    presetn <= 1'b1;
    tick(2 * FC + 6);
    state_is(3'h1);
    for (n = 0; n < 5; n++) rd_chk("reset value", 8'(4 * n), 32'h0);
    apb(1'b0, 8'h1C, 32'h0);
    check("unmapped err", {31'h0, err}, 32'h1);
    check("unmapped data", rd, 32'h0);
    rd_chk("meas", ADDR_MEAS, 32'hA5C3_0F17);
    apb(1'b1, ADDR_STAT, 32'hFFFF_FFFF);
    check("ro write err", {31'h0, err}, 32'h0);
    state_is(3'h1);
    // each function on its own input, odd inputs active low
    for (n = 1; n <= 4; n++) begin
      pm = 4'((n - 1) % 2) << (n - 1);
      cfg = (32'(n) << (4 + 3 * (n - 1))) | 32'(pm);
      apb(1'b1, ADDR_INCFG, cfg);
      rd_chk("incfg", ADDR_INCFG, cfg);
      ctrl_req <= pm;
      tick(SET);
      check("func idle", {31'h0, ui_bit(n)}, 32'h0);
      ctrl_req[n - 1] <= ~pm[n - 1];
      tick(SET);
      check("func active", {31'h0, ui_bit(n)}, 32'h1);
      ctrl_req <= pm;
      tick(SET);
      check("func release", {31'h0, ui_bit(n)}, 32'h0);
    end
    // bounce shorter than the filter
    apb(1'b1, ADDR_INCFG, 32'h10);
    lock_hits = 0;
    rude <= 1'b1;
    ctrl_req <= 4'h1;
    tick(2);
    ctrl_req <= 4'h0;
    tick(1);
    rude <= 1'b0;
    tick(SET);
    check("glitch", {31'h0, ui.lock1}, 32'h0);
    check("glitch hits", 32'(lock_hits), 32'h0);
    apb(1'b1, ADDR_LOCK, 32'h1);
    tick(2);
    check("host lock1", {31'h0, ui.lock1}, 32'h1);
    rd_chk("lock reg", ADDR_LOCK, 32'h1);
    ctrl_req <= 4'h1;
    tick(SET);
    apb(1'b1, ADDR_LOCK, 32'h0);
    tick(2);
    check("or lock1", {31'h0, ui.lock1}, 32'h1);
    ctrl_req <= 4'h0;
    tick(SET);
    check("input lock1", {31'h0, ui.lock1}, 32'h0);
    apb(1'b1, ADDR_LOCK, 32'h2);
    tick(2);
    check("host lock2", {31'h0, ui.lock2}, 32'h1);
    apb(1'b1, ADDR_KEYCMD, 32'h39);
    press(KEY_UP, SET);
    check("lock2 key", {31'h0, ui.dir_swap}, 32'h0);
    apb(1'b1, ADDR_LOCK, 32'h1);
    press(KEY_UP, SET);
    check("lock1 cmd", {31'h0, ui.dir_swap}, 32'h1);
    press(KEY_MENU, 40);
    check("lock1 menu", {31'h0, ui.setup_active}, 32'h0);
    apb(1'b1, ADDR_LOCK, 32'h0);
    tick(2);
    check("host unlock", {31'h0, ui.lock1}, 32'h0);
    press(KEY_DOWN, SET);
    check("down cmd", {31'h0, ui.freeze}, 32'h1);
    pulses = 0;
    press(KEY_ENTER, SET);
    check("enter pulse", 32'(pulses), 32'h1);
    press(KEY_UP, SET);
    check("up cmd", {31'h0, ui.dir_swap}, 32'h0);
    // password survives factory default
    apb(1'b1, ADDR_PWD, 32'h0000_0002);
    rd_chk("pwd wo", ADDR_PWD, 32'h0);
    apb(1'b1, ADDR_LOCK, 32'h3);
    apb(1'b1, ADDR_PROT, 32'h7F);
    apb(1'b1, ADDR_LOCK, 32'h4);
    tick(2);
    check("default lock2", {31'h0, ui.lock2}, 32'h0);
    for (n = 0; n < 4; n++) rd_chk("default", 8'(4 * n), 32'h0);
    press(KEY_MENU, 12);
    check("short hold", {31'h0, ui.setup_active}, 32'h0);
    press(KEY_MENU, 40);
    state_is(3'h3);
    press(KEY_UP, SET);
    check("group up", {29'h0, ui.group}, 32'h1);
    press(KEY_DOWN, SET);
    check("group down", {29'h0, ui.group}, 32'h0);
    tick(20);
    check("menu kept", {31'h0, ui.setup_active}, 32'h1);
    wait_setup(1'b0);
    state_is(3'h1);
    apb(1'b1, ADDR_PROT, 32'h1);
    press(KEY_MENU, 40);
    press(KEY_ENTER, SET);
    state_is(3'h6);
    press(KEY_UP, SET);
    press(KEY_UP, SET);
    press(KEY_ENTER, SET);
    state_is(3'h4);
    press(KEY_ENTER, SET);
    state_is(3'h5);
    tick(40);
    state_is(3'h4);
    press(KEY_MENU, SET);
    press(KEY_MENU, SET);
    state_is(3'h1);
    press(KEY_MENU, 40);
    press(KEY_ENTER, SET);
    press(KEY_UP, SET);
    press(KEY_ENTER, SET);
    state_is(3'h1);
    press(KEY_MENU, 40);
    press(KEY_ENTER, SET);
    wait_setup(1'b0);
    state_is(3'h1);
    finish_test();
  end
endmodule
